// file: logic/brt_map.svh
// offsets, field positions and reset values of the memory tile
// assumes a 5-bit byte address on the plain register port
//
// Contract
// - two independent ports share only the array
// - tile runs whole or as two halves
// - data, address, enables captured on clock
// - address held until next operation unless unlatched
// - optional output stage adds one cycle
// - write read-back: old, new or hold
// - unused tile off; sleep input gates access
// - full port shapes 32Kx1 to 512x72
// - ports may use different shapes
// - half shapes 16Kx1 to 512x36
// - wide widths only in one-read-one-write or fifo mode
// - one side fixed widest in one-read-one-write mode
// - 64-bit words get eight check bits
// - encoder and decoder usable standalone
// - fifo controller advances addresses itself
// - fifo drives full, empty, almost flags
// - almost flags assert at user thresholds
// - fifo sides may differ in width
// - cascade path between adjacent tiles
`ifndef BRT_MAP_SVH
`define BRT_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define BRT_REG_CTRL 5'h00
`define BRT_REG_PCFG 5'h04
`define BRT_REG_THR  5'h08
`define BRT_REG_STAT 5'h0c
`define BRT_REG_FILL 5'h10
// ****************************************
// field positions
// ****************************************
`define BRT_CTRL_EN    0
`define BRT_CTRL_SPLIT 1
`define BRT_CTRL_OROW  2
`define BRT_CTRL_FIFO  3
`define BRT_CTRL_ECC   4
`define BRT_CTRL_NOLAT 5
`define BRT_CTRL_PIPE  6
`define BRT_CTRL_CASC  7
`define BRT_CTRL_CPOS  8
`define BRT_CTRL_FIXRD 9
`define BRT_STAT_SBE   4
`define BRT_STAT_DBE   5
// ****************************************
// reset values and sizes
// ****************************************
`define BRT_CTRL_RST 32'h0000_0001
`define BRT_PCFG_RST 32'h0000_002d
`define BRT_THR_RST  32'h0008_0f80
`define BRT_CAP_FULL 13'h1000
`define BRT_CAP_HALF 13'h0800
`endif

// file: logic/brt_pkg.sv
// types of the memory tile
// assumes brt_map.svh carries the numbers
package brt_pkg;
  // read-back during a write
  typedef enum logic [1:0] {
    BRT_WM_OLD  = 2'b00,
    BRT_WM_NEW  = 2'b01,
    BRT_WM_HOLD = 2'b10
  } brt_wmode_e;
  // one storage row: eight lanes of nine bits
  typedef logic [71:0] brt_row_t;
endpackage

// file: logic/brt_tile.sv
// dual-port memory tile with fifo controller and secded codec
// assumes user logic on ref_clk_in drives both ports and registers
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "brt_map.svh"
module brt_tile
  import brt_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  // register port
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // port a
  input  wire logic        a_en_in,
  input  wire logic        a_we_in,
  input  wire logic [15:0] a_addr_in,
  input  wire logic [71:0] a_wdata_in,
  output logic      [71:0] a_rdata_out,
  // port b
  input  wire logic        b_en_in,
  input  wire logic        b_we_in,
  input  wire logic [15:0] b_addr_in,
  input  wire logic [71:0] b_wdata_in,
  output logic      [71:0] b_rdata_out,
  // power gate and cascade
  input  wire logic        sleep_in,
  input  wire logic [71:0] casc_rdata_in,
  output logic      [71:0] casc_rdata_out,
  // fifo flags
  output logic             fifo_full_out,
  output logic             fifo_empty_out,
  output logic             fifo_afull_out,
  output logic             fifo_aempty_out,
  // ecc status
  output logic             ecc_sbe_out,
  output logic             ecc_dbe_out,
  // standalone codec
  input  wire logic [63:0] enc_data_in,
  output logic      [71:0] enc_code_out,
  input  wire logic [71:0] dec_code_in,
  output logic      [63:0] dec_data_out,
  output logic             dec_sbe_out,
  output logic             dec_dbe_out
);

  // ****************************************
  // helper functions
  // ****************************************

  // row of a word for width code c
  function automatic logic [8:0] row_of(input logic [2:0] c, input logic [14:0] a,
                                        input logic sp);
    logic [14:0] r;
    r = a >> ((sp ? 3'd5 : 3'd6) - c);
    return r[8:0];
  endfunction

  // bit position of a word inside its row
  function automatic logic [6:0] pos_of(input logic [2:0] c, input logic [14:0] a,
                                        input logic sp);
    logic [17:0] b;
    logic [3:0]  ln;
    b  = {3'b000, a} << c;
    ln = {1'b0, b[5:3] & (sp ? 3'd3 : 3'd7)} + ((sp & a[14]) ? 4'd4 : 4'd0);
    return (7'(ln) * 7'd9) + ((c < 3'd3) ? {4'b0000, b[2:0]} : 7'd0);
  endfunction

  // word width in bits for width code c
  function automatic logic [6:0] wbits(input logic [2:0] c);
    case (c)
      3'd0:    return 7'd1;
      3'd1:    return 7'd2;
      3'd2:    return 7'd4;
      3'd3:    return 7'd9;
      3'd4:    return 7'd18;
      3'd5:    return 7'd36;
      default: return 7'd72;
    endcase
  endfunction

  // clamp a requested width to what the mode allows
  function automatic logic [2:0] eff_w(input logic [2:0] req, input logic sp,
                                       input logic wide, input logic fixd);
    logic [2:0] top;
    top = wide ? (sp ? 3'd5 : 3'd6) : (sp ? 3'd4 : 3'd5);
    return (fixd || req > top) ? top : req;
  endfunction

  // hamming code: checks at powers of two, overall parity in bit 0
  function automatic brt_row_t ecc_enc(input logic [63:0] d);
    brt_row_t c;
    int       j;
    logic     x;
    c = '0;
    j = 0;
    for (int i = 1; i < 72; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[j];
        j++;
      end
    end
    for (int p = 0; p < 7; p++) begin
      x = 1'b0;
      for (int i = 1; i < 72; i++) begin
        if (((i >> p) & 1) == 1) x = x ^ c[i];
      end
      c[1 << p] = x;
    end
    c[0] = ^c[71:1];
    return c;
  endfunction

  // decode: {double, single, data}
  function automatic logic [65:0] ecc_dec(input brt_row_t c);
    brt_row_t    w;
    logic [6:0]  s;
    logic [63:0] d;
    logic        par;
    int          j;
    w   = c;
    s   = '0;
    d   = '0;
    j   = 0;
    par = ^c;
    for (int i = 1; i < 72; i++) begin
      if (c[i]) s = s ^ 7'(i);
    end
    if (par && s < 7'd72) w[s] = ~w[s];
    for (int i = 1; i < 72; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[j] = w[i];
        j++;
      end
    end
    return {(s != 7'd0 && !par) || (par && s >= 7'd72), par && s < 7'd72, d};
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl_q;       // mode bits
  logic [31:0] pcfg_q;       // widths and write modes
  logic [31:0] thr_q;        // almost flag thresholds
  logic [31:0] rdata_q;      // read answer
  logic        sbe_q;        // sticky corrected error
  logic        dbe_q;        // sticky uncorrectable error
  logic        cfg_err;      // requested width was clamped
  logic [12:0] fill_q;       // fifo fill in lanes
  logic        dec_sbe;      // port b decode single error
  logic        dec_dbe;      // port b decode double error

  // mode decode
  logic tile_on, split, orow, fifo, ecc_act;
  logic [2:0] wc [2];        // effective width codes

  assign split = ctrl_q[`BRT_CTRL_SPLIT];
  assign orow  = ctrl_q[`BRT_CTRL_OROW];
  assign fifo  = ctrl_q[`BRT_CTRL_FIFO];
  // unused tile stays dark; sleep gates it cycle by cycle
  assign tile_on = ctrl_q[`BRT_CTRL_EN] & ~sleep_in;

  // widths per port, fifo needs whole lanes
  always_comb begin
    wc[0] = eff_w(pcfg_q[2:0], split, orow | fifo, orow & ~ctrl_q[`BRT_CTRL_FIXRD]);
    wc[1] = eff_w(pcfg_q[5:3], split, orow | fifo, orow & ctrl_q[`BRT_CTRL_FIXRD]);
    if (fifo && wc[0] < 3'd3) wc[0] = 3'd3;
    if (fifo && wc[1] < 3'd3) wc[1] = 3'd3;
  end
  assign cfg_err = (wc[0] != pcfg_q[2:0]) | (wc[1] != pcfg_q[5:3]);
  // codec on the array only for full-width 64-bit words
  assign ecc_act = ctrl_q[`BRT_CTRL_ECC] & orow & ~split & (wc[0] == 3'd6)
                   & (wc[1] == 3'd6);

  // register writes; sticky errors: set wins over clear
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= `BRT_CTRL_RST;
      pcfg_q <= `BRT_PCFG_RST;
      thr_q  <= `BRT_THR_RST;
      sbe_q  <= 1'b0;
      dbe_q  <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == `BRT_REG_CTRL) ctrl_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `BRT_REG_PCFG) pcfg_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `BRT_REG_THR) thr_q <= reg_wdata_in;
      if (dec_sbe) begin
        sbe_q <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == `BRT_REG_STAT) begin
        sbe_q <= sbe_q & ~reg_wdata_in[`BRT_STAT_SBE];
      end
      if (dec_dbe) begin
        dbe_q <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == `BRT_REG_STAT) begin
        dbe_q <= dbe_q & ~reg_wdata_in[`BRT_STAT_DBE];
      end
    end
  end

  // read answer one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= '0;
    end else if (!reg_rd_in) begin
      rdata_q <= '0;
    end else if (reg_addr_in == `BRT_REG_CTRL) begin
      rdata_q <= ctrl_q;
    end else if (reg_addr_in == `BRT_REG_PCFG) begin
      rdata_q <= pcfg_q;
    end else if (reg_addr_in == `BRT_REG_THR) begin
      rdata_q <= thr_q;
    end else if (reg_addr_in == `BRT_REG_STAT) begin
      rdata_q <= {25'h0, cfg_err, dbe_q, sbe_q, fifo_aempty_out, fifo_afull_out,
                  fifo_empty_out, fifo_full_out};
    end else if (reg_addr_in == `BRT_REG_FILL) begin
      rdata_q <= {19'h0, fill_q};
    end else begin
      rdata_q <= '0;
    end
  end
  assign reg_rdata_out = rdata_q;
  assign ecc_sbe_out   = sbe_q;
  assign ecc_dbe_out   = dbe_q;

  // ****************************************
  // fifo controller
  // ****************************************
  logic [11:0] wp_q, rp_q;   // lane pointers
  logic [12:0] cap, lw, lr;  // capacity and lanes per word
  logic        push, pop;

  assign cap = split ? `BRT_CAP_HALF : `BRT_CAP_FULL;
  assign lw  = 13'd1 << (wc[0] - 3'd3);
  assign lr  = 13'd1 << (wc[1] - 3'd3);
  // flags from the fill count
  assign fifo_full_out   = fifo & (fill_q > cap - lw);
  assign fifo_empty_out  = fifo & (fill_q < lr);
  assign fifo_afull_out  = fifo & (fill_q >= thr_q[12:0]);
  assign fifo_aempty_out = fifo & (fill_q <= thr_q[28:16]);
  // refused requests leave the pointers alone
  assign push = fifo & tile_on & a_en_in & a_we_in & ~fifo_full_out;
  assign pop  = fifo & tile_on & b_en_in & ~fifo_empty_out;

  // pointers wrap at capacity; leaving fifo mode empties it
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_q   <= '0;
      rp_q   <= '0;
      fill_q <= '0;
    end else if (!fifo) begin
      wp_q   <= '0;
      rp_q   <= '0;
      fill_q <= '0;
    end else begin
      if (push) wp_q <= 12'((wp_q + lw) & (cap - 13'd1));
      if (pop) rp_q <= 12'((rp_q + lr) & (cap - 13'd1));
      fill_q <= fill_q + (push ? lw : 13'd0) - (pop ? lr : 13'd0);
    end
  end

  // ****************************************
  // ports
  // ****************************************
  brt_row_t    mem [512];    // storage, the only shared part
  logic        p_en  [2];
  logic        p_we  [2];
  logic [15:0] p_adr [2];
  brt_row_t    p_wd  [2];
  logic        s_req [2];    // captured request
  logic        s_wr  [2];    // captured write
  logic [15:0] s_adr [2];    // captured address
  brt_row_t    s_wd  [2];    // captured data
  logic [8:0]  row   [2];
  brt_row_t    nrow  [2];    // row after a write
  brt_row_t    dout_q [2];
  brt_row_t    pipe_q [2];

  assign p_en  = '{a_en_in, b_en_in};
  assign p_we  = '{a_we_in, b_we_in};
  assign p_adr = '{a_addr_in, b_addr_in};
  assign p_wd  = '{a_wdata_in, b_wdata_in};

  // port b row through the decoder: {double, single, data}
  logic [65:0] b_dec;
  assign b_dec = ecc_dec(mem[row[1]]);

  for (genvar i = 0; i < 2; i++) begin : g_port
    logic        hit, req, wr;
    logic [15:0] adr;
    logic [6:0]  pos;
    brt_row_t    msk, old, ext;
    brt_wmode_e  wm;

    // cascade: answer only addresses of this tile
    assign hit = ~ctrl_q[`BRT_CTRL_CASC] | (p_adr[i][15] == ctrl_q[`BRT_CTRL_CPOS]);
    // one-read-one-write: a writes only, b reads only
    always_comb begin
      if (fifo) begin
        req = (i == 0) ? push : pop;
        wr  = (i == 0) && push;
        adr = {4'h0, (i == 0 ? wp_q : rp_q) >> (wc[i] - 3'd3)};
      end else begin
        wr  = tile_on & p_en[i] & hit & p_we[i] & (~orow | (i == 0));
        req = wr | (tile_on & p_en[i] & hit & ~p_we[i] & (~orow | (i == 1)));
        adr = p_adr[i];
      end
    end

    // inputs captured; address held between operations
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        s_req[i] <= 1'b0;
        s_wr[i]  <= 1'b0;
        s_adr[i] <= '0;
        s_wd[i]  <= '0;
      end else begin
        s_req[i] <= req;
        s_wr[i]  <= wr;
        s_wd[i]  <= p_wd[i];
        if (req || ctrl_q[`BRT_CTRL_NOLAT]) s_adr[i] <= adr;
      end
    end

    // word placement for this port's own shape
    assign row[i] = row_of(wc[i], s_adr[i][14:0], split);
    assign pos    = pos_of(wc[i], s_adr[i][14:0], split);
    assign msk    = ((72'h1 << wbits(wc[i])) - 72'h1);
    assign old    = mem[row[i]];
    assign ext    = (old >> pos) & msk;
    assign nrow[i] = ecc_act ? ecc_enc(s_wd[i][63:0])
                             : (old & ~(msk << pos)) | ((s_wd[i] << pos) & (msk << pos));
    assign wm     = brt_wmode_e'(pcfg_q[7 + 2 * i -: 2]);

    // read data stage
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        dout_q[i] <= '0;
      end else if (s_req[i] && s_wr[i]) begin
        case (wm)
          BRT_WM_OLD: dout_q[i] <= ext;
          BRT_WM_NEW: dout_q[i] <= s_wd[i] & msk;
          default:    dout_q[i] <= dout_q[i];
        endcase
      end else if (s_req[i]) begin
        dout_q[i] <= (ecc_act && i == 1) ? {8'h00, b_dec[63:0]} : ext;
      end
    end

    // optional output stage
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) pipe_q[i] <= '0;
      else pipe_q[i] <= dout_q[i];
    end
  end

  // both ports write the one array; b wins a same-row collision
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (s_wr[i]) mem[row[i]] <= nrow[i];
    end
  end

  // decode flags for the sticky status
  assign dec_sbe = ecc_act & s_req[1] & ~s_wr[1] & b_dec[64];
  assign dec_dbe = ecc_act & s_req[1] & ~s_wr[1] & b_dec[65];

  // ****************************************
  // outputs and cascade
  // ****************************************
  logic m1_q, m2_q, m3_q;    // port b miss through the stages

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      m1_q <= 1'b0;
      m2_q <= 1'b0;
      m3_q <= 1'b0;
    end else begin
      m1_q <= ctrl_q[`BRT_CTRL_CASC] & b_en_in & (b_addr_in[15] != ctrl_q[`BRT_CTRL_CPOS]);
      if (m1_q) m2_q <= 1'b1;
      else if (s_req[1]) m2_q <= 1'b0;
      m3_q <= m2_q;
    end
  end

  assign a_rdata_out = ctrl_q[`BRT_CTRL_PIPE] ? pipe_q[0] : dout_q[0];
  // lower tile data passes when the address is not ours
  always_comb begin
    if (ctrl_q[`BRT_CTRL_PIPE] ? m3_q : m2_q) b_rdata_out = casc_rdata_in;
    else b_rdata_out = ctrl_q[`BRT_CTRL_PIPE] ? pipe_q[1] : dout_q[1];
  end
  assign casc_rdata_out = b_rdata_out;

  // ****************************************
  // standalone codec
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      enc_code_out <= '0;
      dec_data_out <= '0;
      dec_sbe_out  <= 1'b0;
      dec_dbe_out  <= 1'b0;
    end else begin
      enc_code_out <= ecc_enc(enc_data_in);
      {dec_dbe_out, dec_sbe_out, dec_data_out} <= ecc_dec(dec_code_in);
    end
  end

endmodule

// file: sim/brt_fab.sv
// user fabric model driving both memory ports of the tile
// assumes the tile samples requests on the rising clock edge
`timescale 1ns/1ps
module brt_fab (
  // clock and fifo flags
  input  wire logic        clk_in,
  input  wire logic        full_in,
  input  wire logic        empty_in,
  // port a
  output logic             a_en_out,
  output logic             a_we_out,
  output logic      [15:0] a_addr_out,
  output logic      [71:0] a_wdata_out,
  // port b
  output logic             b_en_out,
  output logic             b_we_out,
  output logic      [15:0] b_addr_out,
  output logic      [71:0] b_wdata_out
);
  // quiet ports from time zero
  initial begin
    {a_en_out, a_we_out, a_addr_out, a_wdata_out} = '0;
    {b_en_out, b_we_out, b_addr_out, b_wdata_out} = '0;
  end

  // one request held for one cycle; rude lets a refused request through
  task automatic op(input logic p, input logic we, input logic [15:0] ad,
                    input logic [71:0] d, input logic rude);
    @(posedge clk_in);
    // polite fabric never pushes when full or pops when empty
    if (!rude && (p ? (!we && empty_in) : (we && full_in))) begin
      return;
    end
    if (p) begin
      {b_en_out, b_we_out, b_addr_out, b_wdata_out} <= {1'b1, we, ad, d};
    end else begin
      {a_en_out, a_we_out, a_addr_out, a_wdata_out} <= {1'b1, we, ad, d};
    end
    @(posedge clk_in);
    {a_en_out, b_en_out} <= 2'b00;
    // released lines no longer show the last value
    {a_addr_out, a_wdata_out} <= ~{a_addr_out, a_wdata_out};
    {b_addr_out, b_wdata_out} <= ~{b_addr_out, b_wdata_out};
  endtask
endmodule

// file: sim/brt_tile_chk.sv
// concurrent checks on the ports of the memory tile
// assumes one clock domain; attached by the bind at the foot
`timescale 1ns/1ps
`include "brt_map.svh"
module brt_tile_chk (
  // clock and reset
  input wire logic        ref_clk_in,
  input wire logic        rstn_in,
  // register port
  input wire logic [4:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // memory ports
  input wire logic        a_en_in,
  input wire logic        b_en_in,
  input wire logic [71:0] a_rdata_out,
  input wire logic [71:0] b_rdata_out,
  input wire logic        sleep_in,
  // fifo flags
  input wire logic        fifo_full_out,
  input wire logic        fifo_empty_out,
  input wire logic        fifo_afull_out,
  input wire logic        fifo_aempty_out,
  // standalone codec
  input wire logic [63:0] enc_data_in,
  input wire logic [71:0] enc_code_out,
  input wire logic [71:0] dec_code_in,
  input wire logic [63:0] dec_data_out,
  input wire logic        dec_sbe_out,
  input wire logic        dec_dbe_out
);
  // flags in status register order
  wire logic [3:0] flags = {fifo_aempty_out, fifo_afull_out, fifo_empty_out, fifo_full_out};

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  // ****************************************
  // register port
  // ****************************************
  AST_RDATA_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data not zero outside read cycle");
  AST_STAT_FLAGS: assert property (reg_rd_in && reg_addr_in == `BRT_REG_STAT |=>
    reg_rdata_out[3:0] == $past(flags)) else $error("status flags differ from pins");

  // ****************************************
  // memory, fifo and codec
  // ****************************************
  AST_SLEEP_HOLD: assert property (sleep_in [*3] |=> $stable(a_rdata_out))
    else $error("port a read data moved while gated");
  AST_FLAG_EXCL: assert property (!(fifo_full_out && fifo_empty_out))
    else $error("fifo full and empty together");
  AST_FULL_HOLD: assert property (fifo_full_out && !b_en_in && !reg_wr_in |=> fifo_full_out)
    else $error("full flag dropped without pop");
  AST_EMPTY_HOLD: assert property (fifo_empty_out && !a_en_in && !reg_wr_in |=>
    fifo_empty_out) else $error("empty flag dropped without push");
  AST_EMPTY_POP: assert property (fifo_empty_out && $past(fifo_empty_out) && !reg_wr_in
    |=> ##1 $stable(b_rdata_out)) else $error("pop on empty fifo changed read data");

  // decoder fed with the encoder's output gives the data back clean
  sequence s_code_fed;
    dec_code_in == enc_code_out;
  endsequence
  property p_roundtrip;
    s_code_fed |=> dec_data_out == $past(enc_data_in, 2) && !dec_sbe_out && !dec_dbe_out;
  endproperty
  AST_CODEC_LOOP: assert property (p_roundtrip)
    else $error("codec round trip failed");
endmodule

bind brt_tile brt_tile_chk i_chk (
  .ref_clk_in, .rstn_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .a_en_in, .b_en_in, .a_rdata_out, .b_rdata_out, .sleep_in,
  .fifo_full_out, .fifo_empty_out, .fifo_afull_out, .fifo_aempty_out,
  .enc_data_in, .enc_code_out, .dec_code_in, .dec_data_out, .dec_sbe_out, .dec_dbe_out
);

// file: sim/dual_port_block_ram_fifo_tb.sv
// self-checking bench for the memory tile
// assumes brt_fab drives both memory ports and brt_tile_chk is bound
`timescale 1ns/1ps
`include "brt_map.svh"
module dual_port_block_ram_fifo_tb
  import brt_pkg::*;
();
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  ra = 5'h00;
  logic [31:0] rwd = 32'h0;
  logic        rwr = 1'b0;
  logic        rrd = 1'b0;
  logic        sleep = 1'b0;
  logic [63:0] enc = 64'h0;
  logic [71:0] dcode = 72'h0;
  logic [31:0] rdat;
  logic        a_en, a_we, b_en, b_we;
  logic [15:0] a_ad, b_ad;
  logic [71:0] a_wd, b_wd, a_rd, b_rd, code;
  logic [63:0] dec_d;
  logic        sbe, dbe, full, empty, afull, aempty;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #50 clk = ~clk;

  brt_tile i_dut (
    .ref_clk_in(clk), .rstn_in(rstn), .reg_addr_in(ra), .reg_wdata_in(rwd),
    .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rdat),
    .a_en_in(a_en), .a_we_in(a_we), .a_addr_in(a_ad), .a_wdata_in(a_wd), .a_rdata_out(a_rd),
    .b_en_in(b_en), .b_we_in(b_we), .b_addr_in(b_ad), .b_wdata_in(b_wd), .b_rdata_out(b_rd),
    .sleep_in(sleep), .casc_rdata_in(72'h0), .casc_rdata_out(),
    .fifo_full_out(full), .fifo_empty_out(empty), .fifo_afull_out(afull),
    .fifo_aempty_out(aempty), .ecc_sbe_out(), .ecc_dbe_out(),
    .enc_data_in(enc), .enc_code_out(code), .dec_code_in(dcode), .dec_data_out(dec_d),
    .dec_sbe_out(sbe), .dec_dbe_out(dbe)
  );

  brt_fab i_fab (
    .clk_in(clk), .full_in(full), .empty_in(empty),
    .a_en_out(a_en), .a_we_out(a_we), .a_addr_out(a_ad), .a_wdata_out(a_wd),
    .b_en_out(b_en), .b_we_out(b_we), .b_addr_out(b_ad), .b_wdata_out(b_wd)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    {ra, rwd, rwr} <= {a, d, 1'b1};
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  task automatic rreg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    {ra, rrd} <= {a, 1'b1};
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    d = rdat;
  endtask
  // one port access, read data taken lat edges after the request edge
  task automatic acc(input logic p, input logic we, input logic [15:0] a,
                     input logic [71:0] d, input int lat, output logic [71:0] q);
    i_fab.op(p, we, a, d, 1'b0);
    repeat (lat) @(posedge clk);
    #1;
    q = p ? b_rd : a_rd;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] v;
    logic [4:0]  ad [6] = '{`BRT_REG_CTRL, `BRT_REG_PCFG, `BRT_REG_THR, `BRT_REG_STAT,
                            `BRT_REG_FILL, 5'h14};
    logic [31:0] ex [6] = '{`BRT_CTRL_RST, `BRT_PCFG_RST, `BRT_THR_RST, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rreg(ad[i], v);
      chk(72'(v), 72'(ex[i]));
    end
  endtask
  // write modes new, old and hold, then cross-port read
  task automatic t_ram();
    logic [71:0] v;
    wreg(`BRT_REG_PCFG, 32'h2d | (32'(BRT_WM_NEW) << 6));
    acc(1'b0, 1'b1, 16'h5, 72'h1_1111_1111, 2, v);
    chk(v, 72'h1_1111_1111);
    acc(1'b1, 1'b0, 16'h5, 72'h0, 2, v);
    chk(v, 72'h1_1111_1111);
    wreg(`BRT_REG_PCFG, 32'h2d | (32'(BRT_WM_OLD) << 6));
    acc(1'b0, 1'b1, 16'h5, 72'h2_2222_2222, 2, v);
    chk(v, 72'h1_1111_1111);
    wreg(`BRT_REG_PCFG, 32'h2d | (32'(BRT_WM_HOLD) << 6));
    acc(1'b0, 1'b1, 16'h5, 72'h3_3333_3333, 2, v);
    chk(v, 72'h1_1111_1111);
    acc(1'b1, 1'b0, 16'h5, 72'h0, 2, v);
    chk(v, 72'h3_3333_3333);
  endtask
  // output stage delays read data by one more cycle
  task automatic t_pipe();
    logic [71:0] v;
    wreg(`BRT_REG_CTRL, 32'h41);
    acc(1'b0, 1'b1, 16'h6, 72'h4_4444_4444, 3, v);
    acc(1'b1, 1'b0, 16'h6, 72'h0, 1, v);
    chk(v, 72'h3_3333_3333);
    tick();
    chk(b_rd, 72'h4_4444_4444);
  endtask
  // gated write, refused write side in one-read-one-write, wide ecc word
  task automatic t_mode();
    logic [71:0] v;
    wreg(`BRT_REG_CTRL, 32'h01);
    sleep <= 1'b1;
    acc(1'b0, 1'b1, 16'h6, 72'h5_5555_5555, 2, v);
    sleep <= 1'b0;
    acc(1'b1, 1'b0, 16'h6, 72'h0, 2, v);
    chk(v, 72'h4_4444_4444);
    wreg(`BRT_REG_CTRL, 32'h05);
    acc(1'b1, 1'b1, 16'h6, 72'h6_6666_6666, 2, v);
    acc(1'b1, 1'b0, 16'h6, 72'h0, 2, v);
    chk(v, 72'h4_4444_4444);
    wreg(`BRT_REG_PCFG, 32'h36);
    wreg(`BRT_REG_CTRL, 32'h15);
    acc(1'b0, 1'b1, 16'h7, 72'hff_0123_4567_89ab_cdef, 2, v);
    acc(1'b1, 1'b0, 16'h7, 72'h0, 2, v);
    chk(v, 72'h00_0123_4567_89ab_cdef);
  endtask
  // standalone codec: clean word, single and double flips
  task automatic t_codec();
    logic [71:0] c;
    enc <= 64'h0123_4567_89ab_cdef;
    tick();
    tick();
    c = code;
    dcode <= c;
    tick();
    tick();
    chk(72'(dec_d), 72'h0123_4567_89ab_cdef);
    for (int k = 0; k < 72; k += 35) begin
      dcode <= c ^ (72'h1 << k);
      tick();
      tick();
      chk(72'({dbe, sbe, dec_d}), {6'h0, 2'b01, 64'h0123_4567_89ab_cdef});
      dcode <= c ^ (72'h3 << k);
      tick();
      tick();
      chk(72'({dbe, sbe}), 72'h2);
    end
  endtask
  // fill until full, refused push, drain in order, refused pop
  task automatic t_fifo();
    logic [71:0] v;
    wreg(`BRT_REG_THR, 32'h0004_0010);
    wreg(`BRT_REG_PCFG, 32'h2d);
    wreg(`BRT_REG_CTRL, 32'h09);
    tick();
    chk(72'({full, empty, afull, aempty}), 72'h5);
    for (int i = 0; i < 1024; i++) begin
      acc(1'b0, 1'b1, 16'h0, 72'(i), 0, v);
      chk(72'({full, empty, afull, aempty}), 72'({i == 1023, 1'b0, i >= 3, i == 0}));
    end
    i_fab.op(1'b0, 1'b1, 16'h0, 72'hfff, 1'b1);
    tick();
    chk(72'(full), 72'h1);
    for (int i = 0; i < 1024; i++) begin
      acc(1'b1, 1'b0, 16'h0, 72'h0, 2, v);
      chk(72'(v[35:0]), 72'(i));
    end
    chk(72'({full, empty, afull, aempty}), 72'h5);
    i_fab.op(1'b1, 1'b0, 16'h0, 72'h0, 1'b1);
    tick();
    tick();
    chk(72'(b_rd[35:0]), 72'd1023);
  endtask

  // ****************************************
  // verdict, timeout and main sequence
  // ****************************************
  task automatic end_sim();
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // cut a hang short well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_ram();
    t_pipe();
    t_mode();
    t_codec();
    t_fifo();
    end_sim();
  end
endmodule
